// ==== include/rub_pkg.sv ====
// rub_pkg: shared constants and types of the run-enable / up-down bias block.
// assumes a single 40 MHz clock domain; register offsets are byte addresses.
package rub_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HOLD_SAVE_MS = 5000;
    localparam int unsigned HOLD_SAVE_CYC = HOLD_SAVE_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STEP = 5'h04;
    localparam logic [4:0] OFS_FREF = 5'h08;
    localparam logic [4:0] OFS_SAVED = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_LIMIT = 5'h14;
    localparam logic [4:0] OFS_RATE = 5'h18;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] STEP_RST = 16'h0000;
    localparam logic [15:0] FREF_RST = 16'h0000;
    localparam logic [15:0] LIMIT_RST = 16'h0100;
    localparam logic [15:0] RATE_RST = 16'h0001;
    localparam logic [15:0] HSB_STEP = 16'h0004;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        STOP_RAMP = 2'b00,
        STOP_COAST = 2'b01,
        STOP_DCINJ = 2'b10,
        STOP_COAST_TMR = 2'b11
    } rub_stop_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_STOPPING = 2'b10,
        ST_HSB = 2'b11
    } rub_state_t;

    // control register layout, bit 7 at the top
    typedef struct packed {
        logic [1:0] run_source_select;
        logic multistep_ref;
        logic pm_olv;
        logic bias_mode_select;
        logic hold_function_select;
        rub_stop_t stop_method_select;
    } rub_ctrl_t;

    // debounced contact inputs
    typedef struct packed {
        logic hsb;
        logic lower;
        logic raise;
        logic enable;
        logic run;
    } rub_pins_t;

endpackage : rub_pkg

// ==== tb/rub_contacts.sv ====
// rub_contacts: switch contacts and a crude motor plant with panel feedback.
// assumes the bench sets sw and one clock drives everything.
`timescale 1ns/1ps
`default_nettype none
module rub_contacts (
    input wire logic clk,
    input wire logic arst_n,
    input wire rub_pkg::rub_pins_t sw,
    input wire logic run_out,
    input wire logic stop_req,
    input wire logic hsb_active,
    input wire logic [15:0] freq_target,
    output var rub_pkg::rub_pins_t pins,
    output logic [15:0] fout,
    output logic speed_agree
);
    // contacts follow the operator; raise and lower are wired independently, like every other contact
    assign pins = sw;
    // plant: tracks the command while driven, coasts down while stopping
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fout <= 16'h0000;
        else if (run_out || hsb_active)
            fout <= freq_target;
        else if (stop_req)
            fout <= (fout > 16'h0010) ? fout - 16'h0010 : 16'h0000;
        else
            fout <= 16'h0000;
    end
    assign speed_agree = (fout == freq_target); // instant agree, kinder than a real drive
endmodule : rub_contacts
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: self-checking bench of rub_core with a contact/plant partner.
// assumes rub_pkg is compiled first; ce is held high throughout.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk, arst_n, wr, rd, cur_limit, bus_limit, speed_agree;
    logic run_out, stop_req, hsb_active, disabled_indication;
    logic [1:0] stop_kind;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [15:0] fref_in, fout, freq_target, t0;
    rub_pkg::rub_pins_t sw, pins;
    int err_total, n_tests, cyc, i, m;
    typedef struct packed {logic r; logic l; logic [15:0] f; logic [15:0] t;} rub_row_t;
    rub_row_t rows [6];

    rub_core #(.SAVE_CYCLES(20)) dut (.clk, .arst_n, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata,
        .run_pin(pins.run), .enable_pin(pins.enable), .raise_pin(pins.raise),
        .lower_pin(pins.lower), .hsb_pin(pins.hsb), .fref_in, .fout, .speed_agree,
        .cur_limit, .bus_limit, .run_out, .stop_req, .stop_kind, .hsb_active,
        .disabled_indication, .freq_target);
    rub_contacts far (.clk, .arst_n, .sw, .run_out, .stop_req, .hsb_active, .freq_target,
        .pins, .fout, .speed_agree);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    // waits n edges, then lets that edge settle before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // contacts pass a four-stage filter, so allow eight edges
    task automatic set_sw(input logic [4:0] s);
        @(posedge clk);
        sw <= s;
        tick(8);
    endtask : set_sw

    // clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, well above the length of the sequence
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence; sw is {hsb, lower, raise, enable, run}
    // ----------------------------------------------------------------
    initial
    begin
        {arst_n, wr, rd, cur_limit, bus_limit, addr, wdata, sw, fref_in} = '0;
        {err_total, n_tests, cyc} = '0;
        rows = '{'{0, 0, 16'h0100, 16'h0100}, '{1, 0, 16'h0100, 16'h0110}, '{0, 1, 16'h0100, 16'h00f0},
            '{1, 1, 16'h0100, 16'h0100}, '{0, 1, 16'h0008, 16'h0000}, '{1, 0, 16'hfff8, 16'hffff}};
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(rub_pkg::OFS_CTRL, v);
        check(v, 32'h0, "ctrl reset");
        rd_reg(rub_pkg::OFS_LIMIT, v);
        check(v, 32'h0100, "limit reset");
        rd_reg(rub_pkg::OFS_RATE, v);
        check(v, 32'h0001, "rate reset");
        rd_reg(5'h1c, v);
        check(v, 32'h0, "unmapped read");
        wr_reg(rub_pkg::OFS_STATUS, 32'hffff);
        set_sw(5'h01);
        check(32'(run_out), 32'h0, "run while disabled");
        check(32'(disabled_indication), 32'h1, "disabled shown");
        set_sw(5'h00);
        rd_reg(rub_pkg::OFS_STATUS, v);
        check(v, 32'h1, "status read-only");
        // run held before enable closes must be cycled
        set_sw(5'h01);
        set_sw(5'h03);
        check(32'(run_out), 32'h0, "run before enable");
        check(32'(disabled_indication), 32'h0, "enabled shown");
        set_sw(5'h02);
        set_sw(5'h03);
        check(32'(run_out), 32'h1, "run after cycle");
        // terminals own the run command before raise/lower are used
        wr_reg(rub_pkg::OFS_CTRL, 32'h40);
        wr_reg(rub_pkg::OFS_STEP, 32'h10);
        for (i = 0; i < 6; i++)
        begin
            set_sw(5'h03);
            @(posedge clk);
            fref_in <= rows[i].f;
            set_sw({1'b0, rows[i].l, rows[i].r, 2'b11});
            check(32'(freq_target), 32'(rows[i].t), "bias target");
        end
        set_sw(5'h03);
        @(posedge clk);
        fref_in <= 16'h0400;
        // every stop method, then DC injection under pm open-loop vector
        for (m = 0; m < 5; m++)
        begin
            wr_reg(rub_pkg::OFS_CTRL, (m < 4) ? 32'h40 | m : 32'h52);
            set_sw(5'h02);
            for (i = 0; i < 200 && stop_req !== 1'b0; i++)
                tick(1);
            set_sw(5'h03);
            check(32'(run_out), 32'h1, "running");
            @(posedge clk);
            sw <= 5'h01;
            for (i = 0; i < 20 && stop_req !== 1'b1; i++)
                tick(1);
            check(32'(stop_kind), (m < 4) ? 32'(m) : 32'h0, "stop kind");
            check(32'(run_out), 32'h0, "run dropped");
        end
        set_sw(5'h02);
        for (i = 0; i < 200 && stop_req !== 1'b0; i++)
            tick(1);
        set_sw(5'h03);
        // high-slip braking: steps down, pauses on a limit
        @(posedge clk);
        sw <= 5'h13;
        for (i = 0; i < 20 && hsb_active !== 1'b1; i++)
            tick(1);
        t0 = freq_target;
        tick(1);
        check(32'(freq_target), 32'(t0 - rub_pkg::HSB_STEP), "hsb step");
        @(posedge clk);
        cur_limit <= 1'b1;
        tick(2);
        t0 = freq_target;
        tick(3);
        check(32'(freq_target), 32'(t0), "hsb pause");
        @(posedge clk);
        cur_limit <= 1'b0;
        for (i = 0; i < 600 && hsb_active !== 1'b0; i++)
            tick(1);
        check(32'(hsb_active), 32'h0, "hsb ended");
        // hold and save, analog then multi-step reference
        wr_reg(rub_pkg::OFS_CTRL, 32'h44);
        @(posedge clk);
        fref_in <= 16'h0200;
        // enable opening mid-braking must still stop by the selected method
        set_sw(5'h11);
        check(32'(hsb_active), 32'h0, "hsb cut by enable");
        check(32'(stop_req), 32'h1, "stop after cut");
        set_sw(5'h02);
        for (i = 0; i < 200 && stop_req !== 1'b0; i++)
            tick(1);
        set_sw(5'h03);
        set_sw(5'h07);
        set_sw(5'h03);
        check(32'(freq_target), 32'h0210, "bias held");
        tick(30);
        rd_reg(rub_pkg::OFS_SAVED, v);
        check(v, 32'h0010, "saved bias");
        @(posedge clk);
        fref_in <= 16'h0201;
        tick(3);
        check(32'(freq_target), 32'h0201, "hold released");
        wr_reg(rub_pkg::OFS_CTRL, 32'h64);
        wr_reg(rub_pkg::OFS_FREF, 32'h0300);
        set_sw(5'h07);
        set_sw(5'h03);
        tick(30);
        rd_reg(rub_pkg::OFS_FREF, v);
        check(v, 32'h0310, "saved reference");
        rd_reg(rub_pkg::OFS_SAVED, v);
        check(v, 32'h0, "saved bias cleared");
        // large reference jump with bias applied, no speed agree
        wr_reg(rub_pkg::OFS_CTRL, 32'h40);
        set_sw(5'h00);
        for (i = 0; i < 300 && stop_req !== 1'b0; i++)
            tick(1);
        set_sw(5'h04);
        @(posedge clk);
        fref_in <= 16'h0400;
        tick(2);
        set_sw(5'h00);
        check(32'(freq_target), 32'h0410, "jump hold");
        rd_reg(rub_pkg::OFS_STATUS, v);
        check(v, 32'h0101, "jump flag");
        // with no step the raise contact ramps the bias at the rate
        wr_reg(rub_pkg::OFS_STEP, 32'h0);
        t0 = freq_target;
        set_sw(5'h04);
        check(32'(freq_target > t0), 32'h1, "raise ramps");
        finish_test();
    end
endmodule : testbench
`default_nettype wire

// ==== verilog/rub_core.sv ====
// rub_core: run-enable gating, stop method choice, high-slip braking and
// up/down bias on the frequency reference, with a plain register port.
// assumes contact pins are asynchronous; fout, speed_agree, limit flags and
// fref_in come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - a high-slip braking request while running lowers the output frequency step by step, pausing while current or bus limits are hit.
// - no run command is carried out while the enable contact is open.
// - the disabled indication is shown while the enable contact is open.
// - a run command already closed when enable closes must be released and closed again before running.
// - enable opening while running starts a stop by the selected stop method.
// - stop method 0 is ramp, 1 coast, 2 DC injection, 3 coast with timer, reset value 0.
// - DC injection is replaced by ramp to stop in permanent-magnet open-loop vector mode.
// - the raise contact increases and the lower contact decreases the frequency reference.
// - with both contacts open the reference is left unchanged.
// - a nonzero bias step sets the target to reference plus or minus the step.
// - with an analog reference and the hold function off, a jump larger than the fluctuation limit holds the bias until speed agree.
// - with hold enabled the bias stays after release until the reference changes.
module rub_core #(
    parameter int unsigned SAVE_CYCLES = rub_pkg::HOLD_SAVE_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic run_pin,
    input wire logic enable_pin,
    input wire logic raise_pin,
    input wire logic lower_pin,
    input wire logic hsb_pin,
    input wire logic [15:0] fref_in,
    input wire logic [15:0] fout,
    input wire logic speed_agree,
    input wire logic cur_limit,
    input wire logic bus_limit,
    output logic run_out,
    output logic stop_req,
    output logic [1:0] stop_kind,
    output logic hsb_active,
    output logic disabled_indication,
    output logic [15:0] freq_target
);

    if (SAVE_CYCLES < 1 || SAVE_CYCLES > 32'h0fffffff)
    begin : g_chk
        $error("SAVE_CYCLES out of range");
    end

    // ----------------------------------------------------------------
    // contact synchronisers
    // ----------------------------------------------------------------
    rub_pkg::rub_pins_t s1_r, s2_r, s3_r, pin_r;

    // a change is taken only when stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end
        else if (ce)
        begin
            s1_r <= {hsb_pin, lower_pin, raise_pin, enable_pin, run_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                pin_r <= s3_r;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    rub_pkg::rub_ctrl_t ctrl_r;
    logic [15:0] step_r, fref_r, saved_r, limit_r, rate_r;
    rub_pkg::rub_state_t state_r;
    logic signed [17:0] bias_r;
    logic save_p;
    logic fhold_r;

    // software writes; a save in the same cycle yields to software
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r <= rub_pkg::CTRL_RST;
            step_r <= rub_pkg::STEP_RST;
            fref_r <= rub_pkg::FREF_RST;
            saved_r <= 16'h0000;
            limit_r <= rub_pkg::LIMIT_RST;
            rate_r <= rub_pkg::RATE_RST;
        end
        else if (ce)
        begin
            if (save_p && ctrl_r.multistep_ref)
            begin
                fref_r <= freq_target;
                saved_r <= 16'h0000;
            end
            else if (save_p)
                saved_r <= bias_r[15:0];
            if (wr)
            begin
                unique case (addr)
                    rub_pkg::OFS_CTRL: ctrl_r <= wdata[7:0];
                    rub_pkg::OFS_STEP: step_r <= wdata[15:0];
                    rub_pkg::OFS_FREF: fref_r <= wdata[15:0];
                    rub_pkg::OFS_SAVED: saved_r <= wdata[15:0];
                    rub_pkg::OFS_LIMIT: limit_r <= wdata[15:0];
                    rub_pkg::OFS_RATE: rate_r <= wdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= 32'h00000000;
        else if (ce)
        begin
            rdata <= 32'h00000000;
            if (rd)
            begin
                unique case (addr)
                    rub_pkg::OFS_CTRL: rdata <= {24'h000000, ctrl_r};
                    rub_pkg::OFS_STEP: rdata <= {16'h0000, step_r};
                    rub_pkg::OFS_FREF: rdata <= {16'h0000, fref_r};
                    rub_pkg::OFS_SAVED: rdata <= {16'h0000, saved_r};
                    rub_pkg::OFS_STATUS: rdata <= {23'h000000, fhold_r, pin_r, state_r, disabled_indication};
                    rub_pkg::OFS_LIMIT: rdata <= {16'h0000, limit_r};
                    rub_pkg::OFS_RATE: rdata <= {16'h0000, rate_r};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // run sequencing
    // ----------------------------------------------------------------
    logic run_ok_r;
    rub_pkg::rub_stop_t kind_nxt;

    // dc injection is unavailable in pm open-loop vector, fall back to ramp
    always_comb
    begin
        kind_nxt = ctrl_r.stop_method_select;
        if (ctrl_r.pm_olv && kind_nxt == rub_pkg::STOP_DCINJ)
            kind_nxt = rub_pkg::STOP_RAMP;
    end

    // run is armed only after seeing it open while enabled
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            run_ok_r <= 1'b0;
        else if (ce)
        begin
            if (!pin_r.enable)
                run_ok_r <= 1'b0;
            else if (!pin_r.run)
                run_ok_r <= 1'b1;
        end
    end

    // main state machine and its registered outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= rub_pkg::ST_IDLE;
            run_out <= 1'b0;
            stop_req <= 1'b0;
            stop_kind <= rub_pkg::STOP_RAMP;
            hsb_active <= 1'b0;
            disabled_indication <= 1'b0;
        end
        else if (ce)
        begin
            disabled_indication <= !pin_r.enable;
            unique case (state_r)
                rub_pkg::ST_IDLE:
                begin
                    if (pin_r.enable && pin_r.run && run_ok_r)
                    begin
                        state_r <= rub_pkg::ST_RUN;
                        run_out <= 1'b1;
                    end
                end
                rub_pkg::ST_RUN:
                begin
                    if (!pin_r.enable || !pin_r.run)
                    begin
                        state_r <= rub_pkg::ST_STOPPING;
                        run_out <= 1'b0;
                        stop_req <= 1'b1;
                        stop_kind <= kind_nxt;
                    end
                    else if (pin_r.hsb)
                    begin
                        state_r <= rub_pkg::ST_HSB;
                        hsb_active <= 1'b1;
                    end
                end
                rub_pkg::ST_HSB:
                begin
                    // enable opening mid-braking still hands over to the chosen stop
                    if (!pin_r.enable)
                    begin
                        state_r <= rub_pkg::ST_STOPPING;
                        run_out <= 1'b0;
                        stop_req <= 1'b1;
                        stop_kind <= kind_nxt;
                        hsb_active <= 1'b0;
                    end
                    else if (fout == 16'h0000)
                    begin
                        state_r <= rub_pkg::ST_IDLE;
                        run_out <= 1'b0;
                        hsb_active <= 1'b0;
                    end
                end
                rub_pkg::ST_STOPPING:
                begin
                    // motor standstill ends the stop
                    if (fout == 16'h0000)
                    begin
                        state_r <= rub_pkg::ST_IDLE;
                        run_out <= 1'b0;
                        stop_req <= 1'b0;
                        hsb_active <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // up/down bias
    // ----------------------------------------------------------------
    logic [15:0] base, base_q_r, fout_q_r;
    logic up, dn, ref_chg, jump;
    logic signed [17:0] up_sum, dn_sum, ref_dif;

    assign base = ctrl_r.multistep_ref ? fref_r : fref_in;
    assign up = pin_r.raise && !pin_r.lower;
    assign dn = pin_r.lower && !pin_r.raise;
    assign ref_chg = base != base_q_r;
    assign up_sum = bias_r + $signed({2'b00, rate_r});
    assign dn_sum = bias_r - $signed({2'b00, rate_r});
    assign ref_dif = $signed({2'b00, base}) - $signed({2'b00, base_q_r});
    assign jump = (ref_dif > $signed({2'b00, limit_r})) || (-ref_dif > $signed({2'b00, limit_r}));

    // previous reference and output frequency for change detection
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            base_q_r <= 16'h0000;
            fout_q_r <= 16'h0000;
        end
        else if (ce)
        begin
            base_q_r <= base;
            fout_q_r <= fout;
        end
    end

    // analog jump during accel/decel keeps the bias until speed agree when the hold function is off
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fhold_r <= 1'b0;
        else if (ce)
        begin
            if (!ctrl_r.multistep_ref && jump && bias_r != 18'sd0)
                fhold_r <= 1'b1;
            else if (speed_agree)
                fhold_r <= 1'b0;
        end
    end

    // bias is bounded to the 16-bit range so the sum never wraps
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            bias_r <= 18'sd0;
        else if (ce)
        begin
            if (save_p && ctrl_r.multistep_ref)
                bias_r <= 18'sd0;
            else if (up && step_r != 16'h0000)
                bias_r <= $signed({2'b00, step_r});
            else if (dn && step_r != 16'h0000)
                bias_r <= -$signed({2'b00, step_r});
            else if (up)
                bias_r <= (up_sum > 18'sd65535) ? 18'sd65535 : up_sum;
            else if (dn)
                bias_r <= (dn_sum < -18'sd65535) ? -18'sd65535 : dn_sum;
            else if (ctrl_r.hold_function_select ? ref_chg : !fhold_r)
                bias_r <= 18'sd0;
            // otherwise both open or both closed: nothing moves
        end
    end

    // ----------------------------------------------------------------
    // hold-and-save timer
    // ----------------------------------------------------------------
    logic [27:0] save_cnt_r;

    // counts while the held output frequency is steady
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            save_cnt_r <= 28'h0000000;
            save_p <= 1'b0;
        end
        else if (ce)
        begin
            save_p <= 1'b0;
            if (!ctrl_r.hold_function_select || up || dn || bias_r == 18'sd0
                || fout != fout_q_r || state_r != rub_pkg::ST_RUN)
                save_cnt_r <= 28'h0000000;
            else if (save_cnt_r == SAVE_CYCLES[27:0] - 28'h0000001)
            begin
                save_cnt_r <= 28'h0000000;
                save_p <= 1'b1;
            end
            else
                save_cnt_r <= save_cnt_r + 28'h0000001;
        end
    end

    // ----------------------------------------------------------------
    // frequency target
    // ----------------------------------------------------------------
    logic signed [17:0] tgt;
    logic [15:0] hsb_dn;

    assign tgt = $signed({2'b00, base}) + bias_r;
    assign hsb_dn = (freq_target > rub_pkg::HSB_STEP) ? freq_target - rub_pkg::HSB_STEP : 16'h0000;

    // high-slip braking pulls the frequency down, pausing at a limit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            freq_target <= 16'h0000;
        else if (ce)
        begin
            if (state_r == rub_pkg::ST_HSB)
            begin
                if (!cur_limit && !bus_limit)
                    freq_target <= hsb_dn;
            end
            else if (tgt < 18'sd0)
                freq_target <= 16'h0000;
            else if (tgt > 18'sd65535)
                freq_target <= 16'hffff;
            else
                freq_target <= tgt[15:0];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_enable_gates_run: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !pin_r.enable |=> !run_out) else $error("ran while disabled");
    a_disabled_shown: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !pin_r.enable |=> disabled_indication) else $error("no disabled indication");
    a_held_run_waits: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !pin_r.enable ##1 ce && pin_r.enable && pin_r.run |=> !run_out)
        else $error("held run started");
    a_disable_stops: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_r == rub_pkg::ST_RUN && !pin_r.enable |=> stop_req && state_r == rub_pkg::ST_STOPPING)
        else $error("no stop on disable");
    a_stop_kind_map: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(stop_req) && !$past(ctrl_r.pm_olv) |-> stop_kind == $past(ctrl_r.stop_method_select))
        else $error("wrong stop kind");
    a_pm_no_dcinj: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(stop_req) && $past(ctrl_r.pm_olv) |-> stop_kind != rub_pkg::STOP_DCINJ)
        else $error("dc injection in pm mode");
    a_raise_grows: assert property (@(posedge clk) disable iff (!arst_n)
        ce && up && step_r == 16'h0000 && rate_r != 16'h0000 && bias_r < 18'sd65535 && !save_p
        |=> bias_r > $past(bias_r)) else $error("raise did not increase");
    a_idle_steady: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !up && !dn && ctrl_r.hold_function_select && !ref_chg && !save_p |=> $stable(bias_r))
        else $error("bias moved while idle");
    a_step_applied: assert property (@(posedge clk) disable iff (!arst_n)
        ce && dn && step_r != 16'h0000 && !save_p |=> bias_r == -$signed({2'b00, $past(step_r)}))
        else $error("step bias wrong");
    a_jump_holds: assert property (@(posedge clk) disable iff (!arst_n)
        ce && fhold_r && !speed_agree && !up && !dn && !ctrl_r.hold_function_select |=> $stable(bias_r))
        else $error("bias dropped before agree");
    a_both_closed: assert property (@(posedge clk) disable iff (!arst_n)
        ce && pin_r.raise && pin_r.lower && !ctrl_r.hold_function_select && fhold_r && !save_p
        |=> $stable(bias_r)) else $error("both closed moved bias");
    a_save_clears: assert property (@(posedge clk) disable iff (!arst_n)
        ce && save_p && ctrl_r.multistep_ref |=> bias_r == 18'sd0) else $error("save kept bias");
    a_hsb_falls: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_r == rub_pkg::ST_HSB && !cur_limit && !bus_limit |=> freq_target <= $past(freq_target))
        else $error("hsb rose");

endmodule : rub_core

`default_nettype wire
